// ===== acis_top.sv
// How it works
// R01 - Bit 15 picks RC or system clock
// R02 - Sample time is 0..31 conversion periods
// R03 - Sample time used only with trigger 111
// R04 - Conversion period equals cycle times divider plus one
// R05 - RC clock ignores the divider field
// R06 - Unimplemented register bits read as zero
// R07 - Buffer words per input are two to field
// R08 - Sample B multi-channel negative input select
// R09 - Sample B multi-channel positive input select
// R10 - Sample A multi-channel negative input select
// R11 - Sample A multi-channel positive input select
// R12 - Wide mode hides multi-channel selects, reads zero
// R13 - Channel zero Sample A negative select
// R14 - Channel zero Sample B negative select
// R15 - Channel zero Sample A positive input select
// R16 - Channel zero Sample B positive input select
// R17 - Second instance software picks inputs 0-15; this block has one instance and its 5-bit positive selects take inputs 0-31
// R18 - Width bit: 12-bit single or 10-bit four
// R19 - Alternate mode swaps Sample A and B
// R20 - Trigger 111 counter ends sampling, starts conversion
// R21 - Counter counts periods from sampling start
`timescale 1ns/1ps
`default_nettype none
module acis_top
   import acis_pkg::*;
(
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic [ACIS_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [ACIS_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   input  wire logic                   rc_osc_in,
   input  wire logic                   sample_start,
   input  wire logic                   sample_end,
   output logic                        tad_tick,
   output logic                        sampling,
   output logic                        conv_start,
   output logic                        sample_b_phase,
   output logic [4:0]                  first_ch_pos_sel,
   output logic                        first_ch_neg_sel,
   output logic                        multi_ch_pos_sel,
   output logic [1:0]                  multi_ch_neg_sel,
   output logic [7:0]                  buffer_words
);

   typedef struct packed {
      logic [15:0]            clk_sample;
      logic [15:0]            dma_buf;
      logic [15:0]            mch_sel;
      logic [15:0]            ch0_sel;
      logic [15:0]            mode_ctrl;
      logic [2:0]             rc_sync;
      logic                   rc_level;
      logic [7:0]             div_cnt;
      logic [4:0]             samp_cnt;
      logic                   tad_tick;
      logic                   sampling;
      logic                   conv_start;
      logic                   phase_b;
      logic [4:0]             ch0_pos;
      logic                   ch0_neg;
      logic                   mch_pos;
      logic [1:0]             mch_neg;
      logic [7:0]             buf_words;
      logic                   aw_held;
      logic [ACIS_ADDR_W-1:0] aw_addr;
      logic                   w_held;
      logic [31:0]            w_data;
      logic [3:0]             w_strb;
      logic                   awready;
      logic                   wready;
      logic                   bvalid;
      logic [1:0]             bresp;
      logic                   arready;
      logic                   rvalid;
      logic [31:0]            rdata;
      logic [1:0]             rresp;
      logic [ACIS_ADDR_W-1:0] rd_addr;
   } acis_state_t;

   acis_state_t s_q;
   acis_state_t s_d;
   logic        tick_now;
   logic        rc_rise;

   // Byte-lane merge into a 16-bit register, keeping only implemented bits
   function automatic logic [15:0] acis_merge(input logic [15:0] old_v, input logic [31:0] wd,
                                              input logic [3:0] strb, input logic [15:0] mask);
      logic [15:0] v;
      v = old_v;
      if (strb[0])
      begin
         v[7:0] = wd[7:0];
      end
      if (strb[1])
      begin
         v[15:8] = wd[15:8];
      end
      return v & mask;
   endfunction

   function automatic logic acis_is_mapped(input logic [ACIS_ADDR_W-1:0] a);
      return (a == ACIS_OFF_CLK_SAMPLE) || (a == ACIS_OFF_DMA_BUF) || (a == ACIS_OFF_MCH_SEL) ||
             (a == ACIS_OFF_CH0_SEL) || (a == ACIS_OFF_MODE_CTRL) || (a == ACIS_OFF_STATUS);
   endfunction

   always_comb
   begin
      logic       rc_sel;
      logic       wide;
      logic       alt;
      logic [2:0] trig;
      logic [4:0] samc;
      logic [7:0] adcs;
      logic       end_now;
      logic [15:0] rd_v;
      s_d      = s_q;
      rc_sel   = s_q.clk_sample[ACIS_RC_BIT];
      samc     = s_q.clk_sample[ACIS_SAMC_LSB +: 5];
      adcs     = s_q.clk_sample[ACIS_ADCS_LSB +: 8];
      trig     = s_q.mode_ctrl[ACIS_TRIG_LSB +: 3];
      wide     = s_q.mode_ctrl[ACIS_WIDE_BIT];
      alt      = s_q.mode_ctrl[ACIS_ALT_BIT];
      end_now  = 1'b0;
      rd_v     = 16'h0000;

      // Oscillator input: first stage feeds only the second; a level counts once stages 2 and 3 agree
      s_d.rc_sync = {s_q.rc_sync[1:0], rc_osc_in};
      if (s_q.rc_sync[1] == s_q.rc_sync[2])
      begin
         s_d.rc_level = s_q.rc_sync[2];
      end
      rc_rise = s_d.rc_level && !s_q.rc_level;

      // Conversion clock period boundary
      if (rc_sel)
      begin
         tick_now    = rc_rise;                        // [R01] [R05]
         s_d.div_cnt = 8'h00;
      end
      else if (s_q.div_cnt >= adcs)
      begin
         tick_now    = 1'b1;                           // [R04]
         s_d.div_cnt = 8'h00;
      end
      else
      begin
         tick_now    = 1'b0;
         s_d.div_cnt = s_q.div_cnt + 8'h01;            // [R04]
      end
      s_d.tad_tick = tick_now;

      // Sampling window
      s_d.conv_start = 1'b0;
      if (!s_q.sampling)
      begin
         if (sample_start)
         begin
            s_d.sampling = 1'b1;
            s_d.samp_cnt = 5'h00;                      // [R21]
         end
      end
      else if (trig == ACIS_TRIG_AUTO)
      begin
         if (tick_now)
         begin
            if (s_q.samp_cnt >= samc)
            begin
               end_now = 1'b1;                         // [R02] [R20] [R21]
            end
            else
            begin
               s_d.samp_cnt = s_q.samp_cnt + 5'h01;
            end
         end
      end
      else if (sample_end)
      begin
         end_now = 1'b1;                               // [R03]
      end
      if (end_now)
      begin
         s_d.sampling   = 1'b0;
         s_d.conv_start = 1'b1;                        // [R20]
         s_d.phase_b    = alt && !s_q.phase_b;         // [R19]
      end
      if (!alt)
      begin
         s_d.phase_b = 1'b0;                           // [R19]
      end

      // Input selects presented to the analog core for the current sample phase
      s_d.ch0_pos = s_q.phase_b ? s_q.ch0_sel[ACIS_CH0_POSB_LSB +: 5]
                                : s_q.ch0_sel[ACIS_CH0_POSA_LSB +: 5];           // [R15] [R16]
      s_d.ch0_neg = s_q.phase_b ? s_q.ch0_sel[ACIS_CH0_NEGB_BIT]
                                : s_q.ch0_sel[ACIS_CH0_NEGA_BIT];                // [R13] [R14]
      if (wide)
      begin
         s_d.mch_pos = 1'b0;                           // [R12] [R18]
         s_d.mch_neg = 2'h0;
      end
      else
      begin
         s_d.mch_pos = s_q.phase_b ? s_q.mch_sel[ACIS_MCH_POSB_BIT]
                                   : s_q.mch_sel[ACIS_MCH_POSA_BIT];             // [R09] [R11]
         s_d.mch_neg = s_q.phase_b ? s_q.mch_sel[ACIS_MCH_NEGB_LSB +: 2]
                                   : s_q.mch_sel[ACIS_MCH_NEGA_LSB +: 2];        // [R08] [R10]
      end
      s_d.buf_words = 8'h01 << s_q.dma_buf[ACIS_DMABL_LSB +: 3];                 // [R07]

      // Write channel: address and data accepted in either order
      if (s_q.awready && s_axi_awvalid)
      begin
         s_d.aw_held = 1'b1;
         s_d.aw_addr = s_axi_awaddr;
      end
      if (s_q.wready && s_axi_wvalid)
      begin
         s_d.w_held = 1'b1;
         s_d.w_data = s_axi_wdata;
         s_d.w_strb = s_axi_wstrb;
      end
      if (s_q.bvalid && s_axi_bready)
      begin
         s_d.bvalid = 1'b0;
      end
      if (s_q.aw_held && s_q.w_held && !s_q.bvalid)
      begin
         s_d.aw_held = 1'b0;
         s_d.w_held  = 1'b0;
         s_d.bvalid  = 1'b1;
         s_d.bresp   = acis_is_mapped(s_q.aw_addr) ? ACIS_RESP_OKAY : ACIS_RESP_SLVERR;
         unique case (s_q.aw_addr)
            ACIS_OFF_CLK_SAMPLE:
               s_d.clk_sample = acis_merge(s_q.clk_sample, s_q.w_data, s_q.w_strb, ACIS_MASK_CLK_SAMPLE);
            ACIS_OFF_DMA_BUF:
               s_d.dma_buf = acis_merge(s_q.dma_buf, s_q.w_data, s_q.w_strb, ACIS_MASK_DMA_BUF);
            ACIS_OFF_MCH_SEL:
               s_d.mch_sel = acis_merge(s_q.mch_sel, s_q.w_data, s_q.w_strb, ACIS_MASK_MCH_SEL);
            ACIS_OFF_CH0_SEL:
               s_d.ch0_sel = acis_merge(s_q.ch0_sel, s_q.w_data, s_q.w_strb, ACIS_MASK_CH0_SEL);
            ACIS_OFF_MODE_CTRL:
               s_d.mode_ctrl = acis_merge(s_q.mode_ctrl, s_q.w_data, s_q.w_strb, ACIS_MASK_MODE_CTRL);
            default:
               s_d.bresp = s_d.bresp;
         endcase
      end
      s_d.awready = !s_d.aw_held && !s_d.bvalid;
      s_d.wready  = !s_d.w_held && !s_d.bvalid;

      // Read channel: one read in flight, answer one cycle after acceptance
      if (s_q.rvalid && s_axi_rready)
      begin
         s_d.rvalid = 1'b0;
      end
      if (s_q.arready && s_axi_arvalid)
      begin
         unique case (s_axi_araddr)
            ACIS_OFF_CLK_SAMPLE: rd_v = s_q.clk_sample & ACIS_MASK_CLK_SAMPLE;           // [R06]
            ACIS_OFF_DMA_BUF:    rd_v = s_q.dma_buf & ACIS_MASK_DMA_BUF;                 // [R06]
            ACIS_OFF_MCH_SEL:    rd_v = wide ? 16'h0000 : (s_q.mch_sel & ACIS_MASK_MCH_SEL); // [R12]
            ACIS_OFF_CH0_SEL:    rd_v = s_q.ch0_sel & ACIS_MASK_CH0_SEL;
            ACIS_OFF_MODE_CTRL:  rd_v = s_q.mode_ctrl & ACIS_MASK_MODE_CTRL;
            ACIS_OFF_STATUS:     rd_v = {14'h0000, s_q.phase_b, s_q.sampling};
            default:             rd_v = 16'h0000;
         endcase
         s_d.rvalid  = 1'b1;
         s_d.rdata   = {16'h0000, rd_v};
         s_d.rresp   = acis_is_mapped(s_axi_araddr) ? ACIS_RESP_OKAY : ACIS_RESP_SLVERR;
         s_d.rd_addr = s_axi_araddr;
      end
      s_d.arready = !s_d.rvalid;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_q            <= '0;
         s_q.clk_sample <= ACIS_RST_REG;
         s_q.dma_buf    <= ACIS_RST_REG;
         s_q.mch_sel    <= ACIS_RST_REG;
         s_q.ch0_sel    <= ACIS_RST_REG;
         s_q.mode_ctrl  <= ACIS_RST_REG;
         s_q.buf_words  <= 8'h01;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign s_axi_awready    = s_q.awready;
   assign s_axi_wready     = s_q.wready;
   assign s_axi_bvalid     = s_q.bvalid;
   assign s_axi_bresp      = s_q.bresp;
   assign s_axi_arready    = s_q.arready;
   assign s_axi_rvalid     = s_q.rvalid;
   assign s_axi_rdata      = s_q.rdata;
   assign s_axi_rresp      = s_q.rresp;
   assign tad_tick         = s_q.tad_tick;
   assign sampling         = s_q.sampling;
   assign conv_start       = s_q.conv_start;
   assign sample_b_phase   = s_q.phase_b;
   assign first_ch_pos_sel = s_q.ch0_pos;
   assign first_ch_neg_sel = s_q.ch0_neg;
   assign multi_ch_pos_sel = s_q.mch_pos;
   assign multi_ch_neg_sel = s_q.mch_neg;
   assign buffer_words     = s_q.buf_words;

   // Divider boundary must yield a period tick one cycle later
   div_tick_a : assert property (@(posedge aclk) disable iff (!aresetn) // [R04]
      (!s_q.clk_sample[ACIS_RC_BIT] && s_q.div_cnt >= s_q.clk_sample[7:0]) |=> tad_tick)
      else $error("divider boundary gave no period tick");

   rc_ignores_div_a : assert property (@(posedge aclk) disable iff (!aresetn) // [R05]
      (s_q.clk_sample[ACIS_RC_BIT] && !rc_rise) |=> !tad_tick)
      else $error("period tick without oscillator edge in rc mode");

   dma_unimpl_a : assert property (@(posedge aclk) disable iff (!aresetn) // [R06]
      (s_axi_rvalid && s_q.rd_addr == ACIS_OFF_DMA_BUF) |-> (s_axi_rdata[31:3] == 29'h0))
      else $error("unimplemented buffer length bits read nonzero");

   wide_hide_a : assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
      s_q.mode_ctrl[ACIS_WIDE_BIT] ##1 s_q.mode_ctrl[ACIS_WIDE_BIT] |-> (!multi_ch_pos_sel && multi_ch_neg_sel == 2'h0))
      else $error("multi-channel select visible in wide mode");

   auto_end_a : assert property (@(posedge aclk) disable iff (!aresetn) // [R20]
      (sampling && s_q.mode_ctrl[2:0] == ACIS_TRIG_AUTO && tick_now && s_q.samp_cnt >= s_q.clk_sample[12:8])
      |=> (!sampling && conv_start) ##1 !conv_start)
      else $error("sample counter did not end sampling");

   manual_hold_a : assert property (@(posedge aclk) disable iff (!aresetn) // [R03]
      (sampling && s_q.mode_ctrl[2:0] != ACIS_TRIG_AUTO && !sample_end) |=> sampling)
      else $error("sampling ended without trigger");

   alt_off_a : assert property (@(posedge aclk) disable iff (!aresetn) // [R19]
      !s_q.mode_ctrl[ACIS_ALT_BIT] |=> !sample_b_phase)
      else $error("sample B used with alternate mode off");

   buf_words_a : assert property (@(posedge aclk) disable iff (!aresetn) // [R07]
      $stable(s_q.dma_buf) |=> (buffer_words == (8'h01 << $past(s_q.dma_buf[2:0]))))
      else $error("buffer words mismatch");
endmodule
`default_nettype wire

// ===== acis_pkg.sv
`default_nettype none
package acis_pkg;
   localparam int unsigned ACIS_ADDR_W   = 6;
   // Register byte addresses (one aligned 32-bit word each)
   localparam logic [5:0] ACIS_OFF_CLK_SAMPLE = 6'h00;
   localparam logic [5:0] ACIS_OFF_DMA_BUF    = 6'h04;
   localparam logic [5:0] ACIS_OFF_MCH_SEL    = 6'h08;
   localparam logic [5:0] ACIS_OFF_CH0_SEL    = 6'h0c;
   localparam logic [5:0] ACIS_OFF_MODE_CTRL  = 6'h10;
   localparam logic [5:0] ACIS_OFF_STATUS     = 6'h14;
   // Implemented-bit masks; all other positions read as zero
   localparam logic [15:0] ACIS_MASK_CLK_SAMPLE = 16'h9fff;
   localparam logic [15:0] ACIS_MASK_DMA_BUF    = 16'h0007;
   localparam logic [15:0] ACIS_MASK_MCH_SEL    = 16'h0707;
   localparam logic [15:0] ACIS_MASK_CH0_SEL    = 16'h9f9f;
   localparam logic [15:0] ACIS_MASK_MODE_CTRL  = 16'h0037;
   // Field positions
   localparam int unsigned ACIS_RC_BIT       = 15;
   localparam int unsigned ACIS_SAMC_LSB     = 8;
   localparam int unsigned ACIS_ADCS_LSB     = 0;
   localparam int unsigned ACIS_DMABL_LSB    = 0;
   localparam int unsigned ACIS_MCH_NEGB_LSB = 9;
   localparam int unsigned ACIS_MCH_POSB_BIT = 8;
   localparam int unsigned ACIS_MCH_NEGA_LSB = 1;
   localparam int unsigned ACIS_MCH_POSA_BIT = 0;
   localparam int unsigned ACIS_CH0_NEGB_BIT = 15;
   localparam int unsigned ACIS_CH0_POSB_LSB = 8;
   localparam int unsigned ACIS_CH0_NEGA_BIT = 7;
   localparam int unsigned ACIS_CH0_POSA_LSB = 0;
   localparam int unsigned ACIS_TRIG_LSB     = 0;
   localparam int unsigned ACIS_WIDE_BIT     = 4;
   localparam int unsigned ACIS_ALT_BIT      = 5;
   // Reset values
   localparam logic [15:0] ACIS_RST_REG = 16'h0000;
   // Trigger source code that lets the sample counter end sampling
   localparam logic [2:0] ACIS_TRIG_AUTO = 3'h7;
   localparam logic [1:0] ACIS_RESP_OKAY   = 2'h0;
   localparam logic [1:0] ACIS_RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ===== acis_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module acis_core_model
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       go,
   input  wire logic [5:0] end_after,
   input  wire logic       sampling,
   output logic            sample_start,
   output logic            sample_end
);
   logic [5:0] cnt_q;
   // Zero end_after leaves ending to the block's own sample counter
   always_ff @(posedge aclk)
   begin
      sample_start <= 1'b0;
      sample_end   <= 1'b0;
      if (!aresetn)
         cnt_q <= 6'h00;
      else
      begin
         if (go && !sampling)
            sample_start <= 1'b1;
         cnt_q <= sampling ? cnt_q + 6'h01 : 6'h00;
         if (sampling && end_after != 6'h00 && cnt_q == end_after - 6'h01)
            sample_end <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ===== test_acis_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_acis_top
   import acis_pkg::*;
();
   logic        aclk = 1'b0, aresetn = 1'b0, go = 1'b0, rc_en = 1'b0, rc_osc_in = 1'b0;
   logic [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00, end_after = 6'h00;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [2:0]  rc_cnt = 3'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, multi_ch_neg_sel;
   logic [31:0] s_axi_rdata;
   logic        sample_start, sample_end, tad_tick, sampling, conv_start, sample_b_phase;
   logic        first_ch_neg_sel, multi_ch_pos_sel;
   logic [4:0]  first_ch_pos_sel;
   logic [7:0]  buffer_words;
   int          failures = 0;
   int          checked = 0;

   acis_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .rc_osc_in, .sample_start, .sample_end, .tad_tick, .sampling, .conv_start,
      .sample_b_phase, .first_ch_pos_sel, .first_ch_neg_sel, .multi_ch_pos_sel, .multi_ch_neg_sel,
      .buffer_words);
   acis_core_model i_core (.aclk, .aresetn, .go, .end_after, .sampling, .sample_start, .sample_end);

   always #2.5 aclk = ~aclk;

   // Slow free-running oscillator stand-in, eight cycles a period
   always @(posedge aclk)
   begin
      rc_cnt    <= rc_en ? rc_cnt + 3'h1 : 3'h0;
      rc_osc_in <= rc_cnt[2];
   end

   task automatic results;
      if (failures == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
      checked++;
      if (g < lo || g > hi)
      begin
         failures++;
         $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic wr(input logic [5:0] a, input logic [15:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= {16'h0000, d};
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1 && n < 50);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
      if (n >= 50)
      begin
         failures++;
         results();
      end
   endtask

   task automatic rchk(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1 && n < 50);
      s_axi_rready <= 1'b0;
      chk("rdata", e, s_axi_rdata);
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
      if (n >= 50)
      begin
         failures++;
         results();
      end
   endtask

   // Returns edges from sampling seen high to the conversion start pulse
   task automatic run(input logic [5:0] ea, output int len);
      int n;
      n   = 0;
      len = 0;
      @(posedge aclk);
      end_after <= ea;
      go        <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      while (sampling !== 1'b1 && n < 20)
      begin
         @(posedge aclk);
         n++;
      end
      while (conv_start !== 1'b1 && len < 400)
      begin
         @(posedge aclk);
         len++;
      end
      if (n >= 20 || len >= 400)
      begin
         failures++;
         results();
      end
   endtask

   task automatic t_regs;
      logic [5:0]  a[4] = '{ACIS_OFF_CLK_SAMPLE, ACIS_OFF_DMA_BUF, ACIS_OFF_MCH_SEL, ACIS_OFF_CH0_SEL};
      logic [15:0] m[4] = '{ACIS_MASK_CLK_SAMPLE, ACIS_MASK_DMA_BUF, ACIS_MASK_MCH_SEL, ACIS_MASK_CH0_SEL};
      // Divider kept below the reserved range that software must not use
      logic [15:0] w[4] = '{16'hff3f, 16'hffff, 16'hffff, 16'hffff};
      chk("buffer_words", 32'h1, {24'h0, buffer_words});
      for (int i = 0; i < 4; i++)
      begin
         rchk(a[i], 32'h0, ACIS_RESP_OKAY);
         wr(a[i], w[i], ACIS_RESP_OKAY);
         rchk(a[i], {16'h0, m[i] & w[i]}, ACIS_RESP_OKAY);
         wr(a[i], 16'h0000, ACIS_RESP_OKAY);
      end
      wr(6'h18, 16'hffff, ACIS_RESP_SLVERR);
      rchk(6'h18, 32'h0, ACIS_RESP_SLVERR);
      for (int i = 0; i < 8; i++)
      begin
         wr(ACIS_OFF_DMA_BUF, 16'(i), ACIS_RESP_OKAY);
         cyc(2);
         chk("buffer_words", 32'h1 << i, {24'h0, buffer_words});
      end
      wr(ACIS_OFF_CH0_SEL, 16'h0f8f, ACIS_RESP_OKAY);
      // Low byte lane only: the high byte must survive
      s_axi_wstrb <= 4'h1;
      wr(ACIS_OFF_CH0_SEL, 16'h0000, ACIS_RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      rchk(ACIS_OFF_CH0_SEL, 32'h0f00, ACIS_RESP_OKAY);
   endtask

   task automatic chk_sel(input logic [4:0] p, input logic n, input logic mp, input logic [1:0] mn);
      chk("first_ch_pos_sel", {27'h0, p}, {27'h0, first_ch_pos_sel});
      chk("first_ch_neg_sel", {31'h0, n}, {31'h0, first_ch_neg_sel});
      chk("multi_ch_pos_sel", {31'h0, mp}, {31'h0, multi_ch_pos_sel});
      chk("multi_ch_neg_sel", {30'h0, mn}, {30'h0, multi_ch_neg_sel});
   endtask

   task automatic t_sel;
      int len;
      wr(ACIS_OFF_CH0_SEL, 16'h059f, ACIS_RESP_OKAY);
      wr(ACIS_OFF_MCH_SEL, 16'h0704, ACIS_RESP_OKAY);
      wr(ACIS_OFF_MODE_CTRL, 16'h0027, ACIS_RESP_OKAY);
      cyc(2);
      chk_sel(5'h1f, 1'b1, 1'b0, 2'h2);
      run(6'h00, len);
      chk_rng("sample_len", 1, 2, len);
      cyc(2);
      chk("sample_b_phase", 32'h1, {31'h0, sample_b_phase});
      chk_sel(5'h05, 1'b0, 1'b1, 2'h3);
      rchk(ACIS_OFF_STATUS, 32'h2, ACIS_RESP_OKAY);
      run(6'h00, len);
      cyc(2);
      chk_sel(5'h1f, 1'b1, 1'b0, 2'h2);
      wr(ACIS_OFF_MODE_CTRL, 16'h0037, ACIS_RESP_OKAY);
      rchk(ACIS_OFF_MODE_CTRL, 32'h37, ACIS_RESP_OKAY);
      cyc(2);
      chk_sel(5'h1f, 1'b1, 1'b0, 2'h0);
      rchk(ACIS_OFF_MCH_SEL, 32'h0, ACIS_RESP_OKAY);
      wr(ACIS_OFF_MODE_CTRL, 16'h0007, ACIS_RESP_OKAY);
      rchk(ACIS_OFF_MCH_SEL, 32'h0704, ACIS_RESP_OKAY);
   endtask

   task automatic t_timing;
      int len;
      wr(ACIS_OFF_CLK_SAMPLE, 16'h0302, ACIS_RESP_OKAY);
      run(6'h00, len);
      chk_rng("sample_len", 10, 13, len);
      wr(ACIS_OFF_MODE_CTRL, 16'h0000, ACIS_RESP_OKAY);
      run(6'd20, len);
      chk_rng("sample_len", 19, 23, len);
   endtask

   task automatic ticks(output int c);
      c = 0;
      repeat (96)
      begin
         @(posedge aclk);
         if (tad_tick === 1'b1)
            c++;
      end
   endtask

   task automatic t_clk;
      int c;
      wr(ACIS_OFF_CLK_SAMPLE, 16'h0003, ACIS_RESP_OKAY);
      cyc(8);
      ticks(c);
      chk_rng("tad_ticks", 24, 24, c);
      rc_en <= 1'b1;
      wr(ACIS_OFF_CLK_SAMPLE, 16'h803f, ACIS_RESP_OKAY);
      cyc(10);
      ticks(c);
      chk_rng("tad_ticks", 11, 13, c);
      rc_en <= 1'b0;
   endtask

   initial
   begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs;
      t_sel;
      t_timing;
      t_clk;
      results();
   end
endmodule
`default_nettype wire
